// ==== hdl/flash_self_program_pkg.sv ====
// Constants, types and timing for the flash self-programming controller
`default_nettype none
package flash_self_program_pkg;
  // Peripheral register addresses and the protect byte's flash address
  localparam logic [15:0] ADDR_PROTECT_CMD = 16'hffa0;
  localparam logic [15:0] ADDR_ERROR_STATUS = 16'hffa1;
  localparam logic [15:0] ADDR_MODE_CONTROL = 16'hffa2;
  localparam logic [15:0] ADDR_OP_SELECT = 16'hffa3;
  localparam logic [15:0] ADDR_PTR_HIGH = 16'hffa4;
  localparam logic [15:0] ADDR_PTR_LOW = 16'hffa5;
  localparam logic [15:0] ADDR_PTR_HIGH_CMP = 16'hffa6;
  localparam logic [15:0] ADDR_PTR_LOW_CMP = 16'hffa7;
  localparam logic [15:0] ADDR_WRITE_BUFFER = 16'hffa8;
  localparam logic [15:0] PROTECT_BYTE_ADDR = 16'h0081;
  // Values
  localparam logic [7:0] PROTECT_KEY = 8'ha5;
  localparam logic [7:0] BLANK_VALUE = 8'hff;
  localparam logic [7:0] BLOCK_LAST = 8'hff;
  // Field positions and reset values
  localparam int SELECT_BIT = 0;
  localparam int MIRROR_LSB = 2;
  localparam int MIRROR_W = 5;
  localparam int ERR_SEQ_BIT = 0;
  localparam int ERR_VERIFY_BIT = 1;
  localparam int ERR_PROTECT_BIT = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [2:0] OP_SELECT_RESET = 3'h0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_VERIFY_BLOCK_NS = 6800000;
  localparam int T_VERIFY_BYTE_NS = 27000;
  localparam int T_ERASE_NS = 8500000;
  localparam int T_BLANK_NS = 480000;
  localparam int T_WRITE_NS = 150000;
  localparam int VERIFY_BLOCK_CYC = (T_VERIFY_BLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VERIFY_BYTE_CYC = (T_VERIFY_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_CYC = (T_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_VERIFY = 3'h1,
    OP_ERASE = 3'h3,
    OP_BLANK = 3'h4,
    OP_WRITE = 3'h5
  } flash_op_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_KEY = 2'h1,
    SEQ_VALUE = 2'h3,
    SEQ_INVERT = 2'h2
  } seq_state_e;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'h0,
    RUN_BUSY = 2'h1,
    RUN_FINISH = 2'h3
  } run_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } store_s;
endpackage
`default_nettype wire

// ==== hdl/flash_self_program_control.sv ====
// Flash self-programming controller: protected mode entry, HALT-driven flash commands
//
// Functional notes
// - HALT in self-programming mode runs the loaded command, then releases HALT itself.
// - Mode changes only through the protected write sequence; single writes leave it unchanged and set error bit 0.
// - Maskable interrupt servicing is blocked while self-programming mode is set.
// - Internal verify takes 6.8 ms per block or 27 us per byte.
// - Block erase clears the numbered block and ends 8.5 ms after HALT.
// - Every erased byte reads back as FFH.
// - Blank check tests the block for erasure and ends 480 us after HALT.
// - Byte write programs the buffer byte at the pointer, ending 150 us after HALT.
// - During a command the CPU fetches nothing and uses no RAM.
// - Interrupt requests are masked, not stored, while the mode is set.
// - Pins hold their HALT standby state during self-programming mode.
// - External security settings are ignored; only the protect byte and the ones-over-zeros write check restrict commands.
// - Flash address 0081H is the protect byte.
// - Select bit 0 chooses normal mode at 0, self-programming at 1.
// - Select bit clears to 0 at reset.
// - Protect byte loads into mode-control bits 2 to 6, read-only.
// - Flash written this way reads back through the ordinary read port.
// - Sequence is key A5H, value, inverse, value; only the last write counts.
// - A broken sequence leaves the mode unchanged and sets error bit 0.
// - Command codes 001 verify, 011 erase, 100 blank check, 101 write; reset 0.
`default_nettype none
module flash_self_program_control #(
  parameter int ADDR_W = 10,
  parameter int VERIFY_BLOCK_CYC = flash_self_program_pkg::VERIFY_BLOCK_CYC,
  parameter int ERASE_CYC = flash_self_program_pkg::ERASE_CYC,
  parameter int BLANK_CYC = flash_self_program_pkg::BLANK_CYC,
  parameter int WRITE_CYC = flash_self_program_pkg::WRITE_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic periph_wr,
  input wire flash_self_program_pkg::store_s periph_store,
  input wire logic periph_rd,
  input wire logic [15:0] periph_rd_addr,
  output logic [7:0] periph_rdata,
  input wire logic halt_exec,
  output logic cpu_stall,
  output logic halt_release,
  output logic standby_enter,
  input wire logic [ADDR_W-1:0] mem_rd_addr,
  output logic [7:0] mem_rd_data,
  input wire logic irq_req,
  output logic irq_forward,
  output logic pin_halt_hold
);
  localparam int BLK_W = ADDR_W - 8;
  localparam int FLASH_BYTES = 1 << ADDR_W;

  // Flash array has no reset; it ships blank
  logic [7:0] mem [FLASH_BYTES] = '{default: flash_self_program_pkg::BLANK_VALUE};
  logic self_program_select;
  logic [flash_self_program_pkg::MIRROR_W-1:0] protect_mirror;
  logic mirror_pending;
  logic [2:0] flash_error_status;
  logic [2:0] flash_operation_select;
  logic [7:0] flash_pointer_high;
  logic [7:0] flash_pointer_low;
  logic [7:0] flash_pointer_high_compare;
  logic [7:0] flash_pointer_low_compare;
  logic [7:0] flash_write_buffer;
  logic [7:0] seq_value;
  flash_self_program_pkg::seq_state_e seq_state;
  flash_self_program_pkg::run_state_e run_state;
  flash_self_program_pkg::flash_op_e cur_op;
  logic [23:0] timer;
  logic [7:0] walk_ptr;
  logic [7:0] walk_end;
  logic walk_done;
  logic [BLK_W-1:0] cur_blk;
  logic cur_protected;

  logic wr_cmd, wr_mode, wr_status;
  logic seq_violation, seq_commit;
  logic op_start, run_end;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] walk_byte;
  logic verify_err_set, protect_err_set;
  logic [2:0] status_set, status_clr;
  logic [BLK_W-1:0] ptr_blk;

  // Protect bit at 0 shields a block; an erased protect byte (FFH) shields nothing
  function automatic logic is_protected(input logic [BLK_W-1:0] blk,
                                        input logic [flash_self_program_pkg::MIRROR_W-1:0] pm);
    is_protected = (int'(blk) < flash_self_program_pkg::MIRROR_W) && !pm[blk];
  endfunction

  function automatic logic [23:0] op_cycles(input logic [2:0] op, input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [8:0] n;
    n = 9'(hi) - 9'(lo) + 9'h001;
    case (op)
      flash_self_program_pkg::OP_VERIFY: begin
        if (lo == flash_self_program_pkg::PTR_RESET && hi == flash_self_program_pkg::BLOCK_LAST) begin
          op_cycles = 24'(VERIFY_BLOCK_CYC);
        end else begin
          op_cycles = 24'(n) * 24'(flash_self_program_pkg::VERIFY_BYTE_CYC);
        end
      end
      flash_self_program_pkg::OP_ERASE: op_cycles = 24'(ERASE_CYC);
      flash_self_program_pkg::OP_BLANK: op_cycles = 24'(BLANK_CYC);
      default: op_cycles = 24'(WRITE_CYC);
    endcase
  endfunction

  assign wr_cmd = periph_wr && periph_store.addr == flash_self_program_pkg::ADDR_PROTECT_CMD;
  assign wr_mode = periph_wr && periph_store.addr == flash_self_program_pkg::ADDR_MODE_CONTROL;
  assign wr_status = periph_wr && periph_store.addr == flash_self_program_pkg::ADDR_ERROR_STATUS;
  assign ptr_blk = flash_pointer_high[BLK_W-1:0];

  // Protected write sequence
  always_comb begin
    seq_violation = 1'b0;
    seq_commit = 1'b0;
    if (periph_wr) begin
      case (seq_state)
        flash_self_program_pkg::SEQ_IDLE: begin
          seq_violation = wr_mode || (wr_cmd && periph_store.data != flash_self_program_pkg::PROTECT_KEY);
        end
        flash_self_program_pkg::SEQ_KEY: seq_violation = !wr_mode;
        flash_self_program_pkg::SEQ_VALUE: seq_violation = !wr_mode || periph_store.data != ~seq_value;
        flash_self_program_pkg::SEQ_INVERT: begin
          seq_violation = !wr_mode || periph_store.data != seq_value;
          seq_commit = !seq_violation;
        end
        default: seq_violation = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_state <= flash_self_program_pkg::SEQ_IDLE;
      seq_value <= 8'h00;
    end else if (periph_wr) begin
      if (seq_violation) begin
        seq_state <= flash_self_program_pkg::SEQ_IDLE;
      end else begin
        case (seq_state)
          flash_self_program_pkg::SEQ_IDLE: begin
            if (wr_cmd) begin
              seq_state <= flash_self_program_pkg::SEQ_KEY;
            end
          end
          flash_self_program_pkg::SEQ_KEY: begin
            seq_value <= periph_store.data;
            seq_state <= flash_self_program_pkg::SEQ_VALUE;
          end
          flash_self_program_pkg::SEQ_VALUE: seq_state <= flash_self_program_pkg::SEQ_INVERT;
          default: seq_state <= flash_self_program_pkg::SEQ_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      self_program_select <= 1'b0;
    end else if (seq_commit) begin
      self_program_select <= periph_store.data[flash_self_program_pkg::SELECT_BIT];
    end
  end

  // Mirror is caught one clock after release, never from the reset branch
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mirror_pending <= 1'b1;
      protect_mirror <= '1;
    end else if (mirror_pending) begin
      mirror_pending <= 1'b0;
      protect_mirror <= mem[flash_self_program_pkg::PROTECT_BYTE_ADDR[ADDR_W-1:0]][flash_self_program_pkg::MIRROR_W-1:0];
    end
  end

  // Plain command and pointer registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_operation_select <= flash_self_program_pkg::OP_SELECT_RESET;
      flash_pointer_high <= flash_self_program_pkg::PTR_RESET;
      flash_pointer_low <= flash_self_program_pkg::PTR_RESET;
      flash_pointer_high_compare <= flash_self_program_pkg::PTR_RESET;
      flash_pointer_low_compare <= flash_self_program_pkg::PTR_RESET;
      flash_write_buffer <= flash_self_program_pkg::PTR_RESET;
    end else if (periph_wr) begin
      case (periph_store.addr)
        flash_self_program_pkg::ADDR_OP_SELECT: flash_operation_select <= periph_store.data[2:0];
        flash_self_program_pkg::ADDR_PTR_HIGH: flash_pointer_high <= periph_store.data;
        flash_self_program_pkg::ADDR_PTR_LOW: flash_pointer_low <= periph_store.data;
        flash_self_program_pkg::ADDR_PTR_HIGH_CMP: flash_pointer_high_compare <= periph_store.data;
        flash_self_program_pkg::ADDR_PTR_LOW_CMP: flash_pointer_low_compare <= periph_store.data;
        flash_self_program_pkg::ADDR_WRITE_BUFFER: flash_write_buffer <= periph_store.data;
        default: ;
      endcase
    end
  end

  // Error flags: write 0 clears, a same-cycle hardware set wins
  assign status_set = {protect_err_set, verify_err_set, seq_violation};
  assign status_clr = wr_status ? ~periph_store.data[2:0] : 3'h0;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_error_status <= flash_self_program_pkg::STATUS_RESET;
    end else begin
      flash_error_status <= (flash_error_status & ~status_clr) | status_set;
    end
  end

  // Command engine; reserved codes still count as a command and only time out
  assign op_start = halt_exec && self_program_select && run_state == flash_self_program_pkg::RUN_IDLE;
  assign run_end = run_state == flash_self_program_pkg::RUN_BUSY && timer == 24'h0 && walk_done;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_state <= flash_self_program_pkg::RUN_IDLE;
      cur_op <= flash_self_program_pkg::OP_NONE;
      timer <= 24'h0;
      walk_ptr <= 8'h00;
      walk_end <= 8'h00;
      walk_done <= 1'b1;
      cur_blk <= '0;
      cur_protected <= 1'b0;
    end else begin
      case (run_state)
        flash_self_program_pkg::RUN_IDLE: begin
          if (op_start) begin
            run_state <= flash_self_program_pkg::RUN_BUSY;
            cur_op <= flash_self_program_pkg::flash_op_e'(flash_operation_select);
            timer <= op_cycles(flash_operation_select, flash_pointer_low,
                               flash_pointer_low_compare) - 24'h1;
            cur_blk <= ptr_blk;
            cur_protected <= is_protected(ptr_blk, protect_mirror);
            if (flash_operation_select == flash_self_program_pkg::OP_VERIFY) begin
              walk_ptr <= flash_pointer_low;
              walk_end <= flash_pointer_low_compare;
              walk_done <= flash_pointer_low_compare < flash_pointer_low;
            end else begin
              walk_ptr <= 8'h00;
              walk_end <= flash_self_program_pkg::BLOCK_LAST;
              walk_done <= flash_operation_select != flash_self_program_pkg::OP_ERASE &&
                           flash_operation_select != flash_self_program_pkg::OP_BLANK;
            end
          end
        end
        flash_self_program_pkg::RUN_BUSY: begin
          if (timer != 24'h0) begin
            timer <= timer - 24'h1;
          end
          if (!walk_done) begin
            walk_ptr <= walk_ptr + 8'h01;
            walk_done <= walk_ptr == walk_end;
          end
          if (run_end) begin
            run_state <= flash_self_program_pkg::RUN_FINISH;
          end
        end
        default: run_state <= flash_self_program_pkg::RUN_IDLE;
      endcase
    end
  end

  assign walk_byte = mem[{cur_blk, walk_ptr}];

  always_comb begin
    mem_we = 1'b0;
    mem_wa = {cur_blk, walk_ptr};
    mem_wd = flash_self_program_pkg::BLANK_VALUE;
    verify_err_set = 1'b0;
    protect_err_set = 1'b0;
    if (run_state == flash_self_program_pkg::RUN_BUSY) begin
      case (cur_op)
        flash_self_program_pkg::OP_ERASE: begin
          mem_we = !walk_done && !cur_protected;
          protect_err_set = cur_protected && run_end;
        end
        flash_self_program_pkg::OP_BLANK: begin
          verify_err_set = !walk_done && walk_byte != flash_self_program_pkg::BLANK_VALUE;
        end
        flash_self_program_pkg::OP_VERIFY: begin
          verify_err_set = run_end && flash_pointer_low_compare < flash_pointer_low;
        end
        flash_self_program_pkg::OP_WRITE: begin
          mem_wa = {ptr_blk, flash_pointer_low};
          mem_wd = flash_write_buffer;
          // Ones may not be programmed over bits that are already zero
          protect_err_set = run_end && (cur_protected || |(flash_write_buffer & ~mem[mem_wa]));
          mem_we = run_end && !protect_err_set;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    mem_rd_data <= mem[mem_rd_addr];
  end

  // Register readback
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      periph_rdata <= 8'h00;
    end else if (periph_rd) begin
      case (periph_rd_addr)
        flash_self_program_pkg::ADDR_ERROR_STATUS: periph_rdata <= {5'h00, flash_error_status};
        flash_self_program_pkg::ADDR_MODE_CONTROL: begin
          periph_rdata <= {1'b0, protect_mirror, 1'b0, self_program_select};
        end
        flash_self_program_pkg::ADDR_OP_SELECT: periph_rdata <= {5'h00, flash_operation_select};
        flash_self_program_pkg::ADDR_PTR_HIGH: periph_rdata <= flash_pointer_high;
        flash_self_program_pkg::ADDR_PTR_LOW: periph_rdata <= flash_pointer_low;
        flash_self_program_pkg::ADDR_PTR_HIGH_CMP: periph_rdata <= flash_pointer_high_compare;
        flash_self_program_pkg::ADDR_PTR_LOW_CMP: periph_rdata <= flash_pointer_low_compare;
        flash_self_program_pkg::ADDR_WRITE_BUFFER: periph_rdata <= flash_write_buffer;
        default: periph_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      standby_enter <= 1'b0;
    end else begin
      standby_enter <= halt_exec && !self_program_select;
    end
  end

  assign cpu_stall = run_state != flash_self_program_pkg::RUN_IDLE;
  assign halt_release = run_state == flash_self_program_pkg::RUN_FINISH;
  // Requests are masked while the mode is set; nothing is stored, so only a request still raised passes once the mode is left
  assign irq_forward = irq_req && !self_program_select;
  assign pin_halt_hold = self_program_select;

  // Helper: cycles spent in the busy state
  logic [23:0] run_len;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_len <= 24'h0;
    end else if (op_start) begin
      run_len <= 24'h0;
    end else if (run_state == flash_self_program_pkg::RUN_BUSY) begin
      run_len <= run_len + 24'h1;
    end
  end

  property p_single_write_ignored;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_mode && seq_state == flash_self_program_pkg::SEQ_IDLE |=>
        $stable(self_program_select) && flash_error_status[0];
  endproperty
  a_single_write_ignored: assert property (p_single_write_ignored) else $error("mode changed by single write");

  property p_sequence_commit;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_cmd && periph_store.data == flash_self_program_pkg::PROTECT_KEY &&
      seq_state == flash_self_program_pkg::SEQ_IDLE ##1 wr_mode ##1 wr_mode ##1 wr_mode |=>
        self_program_select == $past(seq_value[0]) || flash_error_status[0];
  endproperty
  a_sequence_commit: assert property (p_sequence_commit) else $error("sequence outcome wrong");

  property p_violation_keeps_mode;
    @(posedge ref_clk) disable iff (sys_rst)
      seq_violation |=> $stable(self_program_select) && flash_error_status[0];
  endproperty
  a_violation_keeps_mode: assert property (p_violation_keeps_mode) else $error("violation not flagged");

  property p_irq_blocked;
    @(posedge ref_clk) disable iff (sys_rst)
      self_program_select |-> !irq_forward && pin_halt_hold;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked) else $error("irq passed in mode");

  property p_erase_time;
    @(posedge ref_clk) disable iff (sys_rst)
      halt_release && cur_op == flash_self_program_pkg::OP_ERASE |-> run_len == 24'(ERASE_CYC);
  endproperty
  a_erase_time: assert property (p_erase_time) else $error("erase time wrong");

  property p_blank_write_time;
    @(posedge ref_clk) disable iff (sys_rst)
      halt_release |-> (cur_op != flash_self_program_pkg::OP_BLANK || run_len == 24'(BLANK_CYC)) &&
        (cur_op != flash_self_program_pkg::OP_WRITE || run_len == 24'(WRITE_CYC));
  endproperty
  a_blank_write_time: assert property (p_blank_write_time) else $error("blank or write time wrong");

  property p_erase_blank;
    @(posedge ref_clk) disable iff (sys_rst)
      mem_we && cur_op == flash_self_program_pkg::OP_ERASE |=>
        mem[$past(mem_wa)] == flash_self_program_pkg::BLANK_VALUE;
  endproperty
  a_erase_blank: assert property (p_erase_blank) else $error("erase wrote non-blank");

  property p_normal_halt;
    @(posedge ref_clk) disable iff (sys_rst)
      halt_exec && !self_program_select && !cpu_stall |=> !cpu_stall && standby_enter;
  endproperty
  a_normal_halt: assert property (p_normal_halt) else $error("flash op in normal mode");

  property p_stall_until_release;
    @(posedge ref_clk) disable iff (sys_rst)
      op_start || (cpu_stall && !halt_release) |=> cpu_stall;
  endproperty
  a_stall_until_release: assert property (p_stall_until_release) else $error("stall dropped early");

  property p_mirror_read_only;
    @(posedge ref_clk) disable iff (sys_rst)
      !mirror_pending |=> $stable(protect_mirror);
  endproperty
  a_mirror_read_only: assert property (p_mirror_read_only) else $error("mirror bits changed");

  c_erase_done: cover property (@(posedge ref_clk) disable iff (sys_rst)
    halt_release && cur_op == flash_self_program_pkg::OP_ERASE);
  c_mode_entry: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(self_program_select));
  c_seq_error: cover property (@(posedge ref_clk) disable iff (sys_rst) seq_violation);
  c_write_done: cover property (@(posedge ref_clk) disable iff (sys_rst)
    halt_release && cur_op == flash_self_program_pkg::OP_WRITE);
endmodule // flash_self_program_control
`default_nettype wire

// ==== testbench/cpu_program_model.sv ====
// User program model: register stores, reads and HALT from the CPU side
`default_nettype none
module cpu_program_model (
  input wire logic ref_clk,
  output logic periph_wr,
  output var flash_self_program_pkg::store_s periph_store,
  output logic periph_rd,
  output logic [15:0] periph_rd_addr,
  output logic halt_exec
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    periph_wr = 1'b0;
    periph_store = '0;
    periph_rd = 1'b0;
    periph_rd_addr = 16'h0000;
    halt_exec = 1'b0;
  end
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    periph_wr <= 1'b1;
    periph_store <= '{addr: a, data: d};
    @(posedge ref_clk);
  endtask
  // Released lines show a changed pattern so stale values cannot pass
  task automatic idle();
    periph_wr <= 1'b0;
    periph_rd <= 1'b0;
    halt_exec <= 1'b0;
    periph_store <= ~periph_store;
    @(posedge ref_clk);
  endtask
  task automatic read(input logic [15:0] a);
    periph_rd <= 1'b1;
    periph_rd_addr <= a;
    @(posedge ref_clk);
    idle();
  endtask
  task automatic enter(input logic [7:0] v);
    store(16'hffa0, 8'ha5);
    store(16'hffa2, v);
    store(16'hffa2, ~v);
    store(16'hffa2, v);
    idle();
    repeat (2000) @(posedge ref_clk);
  endtask
  task automatic load(input logic [2:0] op, input logic [7:0] lo, input logic [7:0] d);
    store(16'hffa4, 8'h00);
    store(16'hffa5, lo);
    store(16'hffa6, 8'h00);
    store(16'hffa7, 8'hff);
    store(16'hffa8, d);
    store(16'hffa3, {5'h00, op});
    idle();
  endtask
  task automatic halt();
    halt_exec <= 1'b1;
    @(posedge ref_clk);
    halt_exec <= 1'b0;
  endtask
endmodule // cpu_program_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the flash self-programming controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic irq_req = 1'b1;
  logic [9:0] mem_rd_addr = 10'h000;
  logic periph_wr, periph_rd, halt_exec, cpu_stall, halt_release, standby_enter;
  logic irq_forward, pin_halt_hold;
  flash_self_program_pkg::store_s periph_store;
  logic [15:0] periph_rd_addr;
  logic [7:0] periph_rdata, mem_rd_data;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 ref_clk = ~ref_clk;
  cpu_program_model i_cpu (.ref_clk(ref_clk), .periph_wr(periph_wr),
    .periph_store(periph_store), .periph_rd(periph_rd),
    .periph_rd_addr(periph_rd_addr), .halt_exec(halt_exec));
  flash_self_program_control #(.VERIFY_BLOCK_CYC(300), .ERASE_CYC(300), .BLANK_CYC(300),
    .WRITE_CYC(300)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .periph_wr(periph_wr),
    .periph_store(periph_store), .periph_rd(periph_rd), .periph_rd_addr(periph_rd_addr),
    .periph_rdata(periph_rdata), .halt_exec(halt_exec), .cpu_stall(cpu_stall),
    .halt_release(halt_release), .standby_enter(standby_enter), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .irq_req(irq_req), .irq_forward(irq_forward),
    .pin_halt_hold(pin_halt_hold));
  task automatic final_report();
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      bad_count = bad_count + 1;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    i_cpu.read(a);
    chk(16'(periph_rdata), 16'(exp));
  endtask
  task automatic mem_chk(input logic [9:0] a, input logic [7:0] exp);
    mem_rd_addr <= a;
    repeat (2) @(posedge ref_clk);
    chk(16'(mem_rd_data), 16'(exp));
  endtask
  // Counts cycles from HALT to release; expected 300 busy cycles plus one
  task automatic run_op();
    logic [15:0] n;
    n = 16'h0000;
    i_cpu.halt();
    // Loop ceiling stands in for the watchdog that software restarts first
    while (halt_release !== 1'b1 && n < 16'h07d0) begin
      @(negedge ref_clk);
      n = n + 16'h0001;
      if (n == 16'h0001) chk(16'(cpu_stall), 16'h0001);
    end
    chk(n, 16'h012d);
    chk(16'(cpu_stall), 16'h0001);
    @(posedge ref_clk);
  endtask
  task automatic t_reset(input logic [7:0] mode);
    sys_rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_chk(16'hffa2, mode);
    rd_chk(16'hffa1, 8'h00);
    rd_chk(16'hffa3, 8'h00);
    i_cpu.halt();
    @(negedge ref_clk);
    chk(16'(standby_enter), 16'h0001);
    chk(16'(cpu_stall), 16'h0000);
    @(posedge ref_clk);
  endtask
  task automatic t_refuse();
    i_cpu.store(16'hffa2, 8'h01);
    i_cpu.idle();
    rd_chk(16'hffa1, 8'h01);
    rd_chk(16'hffa2, 8'h7c);
    i_cpu.store(16'hffa1, 8'h00);
    i_cpu.idle();
    rd_chk(16'hffa1, 8'h00);
  endtask
  task automatic t_enter();
    chk(16'(irq_forward), 16'h0001);
    i_cpu.enter(8'hff);
    rd_chk(16'hffa2, 8'h7d);
    chk(16'(pin_halt_hold), 16'h0001);
    chk(16'(irq_forward), 16'h0000);
  endtask
  task automatic t_ops();
    i_cpu.load(3'h5, 8'h10, 8'h5a);
    run_op();
    mem_chk(10'h010, 8'h5a);
    i_cpu.load(3'h1, 8'h00, 8'h5a);
    run_op();
    i_cpu.load(3'h4, 8'h00, 8'h5a);
    run_op();
    rd_chk(16'hffa1, 8'h02);
    i_cpu.load(3'h3, 8'h00, 8'h5a);
    run_op();
    mem_chk(10'h010, 8'hff);
    i_cpu.load(3'h5, 8'h81, 8'hfe);
    run_op();
  endtask
  // Protect byte now shields block 0: erase must be refused
  task automatic t_protect();
    i_cpu.enter(8'hff);
    i_cpu.load(3'h3, 8'h00, 8'h00);
    run_op();
    rd_chk(16'hffa1, 8'h04);
    mem_chk(10'h081, 8'hfe);
  endtask
  initial begin
    t_reset(8'h7c);
    t_refuse();
    t_enter();
    t_ops();
    t_reset(8'h78);
    t_protect();
    final_report();
  end
endmodule // testbench
`default_nettype wire
